/* adcsp_host.sv */
`timescale 1ns/1ps
// Host side; released pins settle to the pull-down level.
module adcsp_host (
  input  wire logic clk,
  input  wire logic sclk_out,
  input  wire logic sclk_oe,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  input  wire logic data_ready_n,
  output logic      cs_n,
  output logic      sclk_in
);
  wire sclk_pin = sclk_oe & sclk_out;
  wire sdo_pin  = sdo_oe & sdo;

  initial begin
    cs_n    = 1'b1;
    sclk_in = 1'b0;
  end

  task automatic hold_low;
    cs_n = 1'b0;
  endtask

  task automatic read_self(output logic [23:0] w, output int lead, output int span, output int tail);
    int   c;
    int   n;
    logic prev;
    c = -1;
    n = 0;
    prev = 1'b0;
    w = '0;
    lead = 0;
    span = 0;
    tail = 0;
    @(negedge clk);
    cs_n = 1'b0;
    for (int k = 0; k < 200 && tail == 0; k++) begin
      @(posedge clk);
      #1;
      if (c >= 0) c++;
      if (c < 0 && sclk_oe) c = 0;
      if (sclk_pin && !prev) begin
        if (n == 0) lead = c;
        w = {w[22:0], sdo_pin};
        n++;
        if (n == 24) begin
          span = c - lead;
          c = 0;
        end
      end
      prev = sclk_pin;
      if (n == 24 && data_ready_n) tail = c;
    end
    @(negedge clk);
    cs_n = 1'b1;
  endtask

  // Host clocks the word out, selecting at once without waiting for ready to fall.
  // Every host pin change lands on a master clock falling edge, since the caller returns on one.
  task automatic read_ext(output logic [23:0] w, output int tail);
    w = '0;
    tail = 0;
    cs_n = 1'b0;
    #300;
    for (int i = 0; i < 24; i++) begin
      sclk_in = 1'b1;
      w = {w[22:0], sdo_pin};
      #100;
      sclk_in = 1'b0;
      if (i < 23) #100;
    end
    while (!data_ready_n && tail < 20) begin
      @(posedge clk);
      #1;
      tail++;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
  endtask
endmodule // adcsp_host

/* adcsp_port.sv */
`timescale 1ns/1ps
// Operation
// [RULE1] The strap picks self-clocked mode when high and externally clocked mode when low.
// [RULE2] In self-clocked mode both serial clock and data outputs float while chip select is high.
// [RULE3] In self-clocked mode the first serial clock rise comes 8 cycles after chip select falls.
// [RULE4] In self-clocked mode the MSB is driven once chip select is low after ready has fallen.
// [RULE5] In self-clocked mode ready returns high 8 cycles after the last serial clock rise.
// [RULE6] In externally clocked mode the host supplies the serial clock and shifts the word out.
// [RULE7] In externally clocked mode data floats while chip select is high and is driven when low.
// [RULE8] In externally clocked mode the host keeps chip select high until after ready falls.
// [RULE9] In externally clocked mode ready returns high after the serial clock fall ending the word.
// [RULE10] The filter result is taken 160 cycles into the 354-cycle high-power phase.
// [RULE11] In self-clocked mode the serial clock is the master clock divided by two.
// [RULE12] The word is shifted out MSB first, one bit per serial clock, until all bits are sent.
// [RULE13] Each result at the port is a 24-bit word.
// [RULE14] At conversion end the result is loaded into the port and ready is driven low.
// [RULE15] Ready rises once every bit of the word has left the port.
// [RULE16] An unread word with chip select low lets ready rise two cycles before the next conversion ends.
module adcsp_port
  import adcsp_pkg::*;
#(
  parameter int WORD_W = ADCSP_WORD_W
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              conv_start,
  input  wire logic [WORD_W-1:0] filt_data,
  input  wire logic              serial_mode_strap,
  input  wire logic              cs_n,
  input  wire logic              sclk_in,
  output logic                   sclk_out,
  output logic                   sclk_oe,
  output logic                   sdo,
  output logic                   sdo_oe,
  output logic                   data_ready_n
);
  localparam int BW = $clog2(WORD_W + 1);

  // [RULE13] word width check
  if (WORD_W < 2 || WORD_W > 32) begin : g_bad_width
    $error("adcsp_port: WORD_W must lie between 2 and 32");
  end

  adcsp_pins_s                 pins;
  adcsp_state_e                state;
  logic        [ADCSP_PH_CNT_W-1:0]   ph_cnt;
  logic        [ADCSP_CONV_CNT_W-1:0] conv_cnt;
  logic                        conv_busy;
  logic        [WORD_W-1:0]    filt_hold;
  logic        [WORD_W-1:0]    sreg;
  logic        [BW-1:0]        bit_cnt;
  logic                        sclk_d;
  logic                        mode_ssc;
  logic                        cs_low;
  logic                        load;
  logic                        ssc_shift;
  logic                        sec_shift;
  logic                        ssc_done;
  logic                        sec_done;
  logic                        early_release;

  // Strap, chip select and host clock all come from pins.
  adcsp_sync #(
    .W ($bits(adcsp_pins_s))
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .async_in ({serial_mode_strap, cs_n, sclk_in}),
    .sync_out (pins)
  );

  // [RULE1] mode from strap
  assign mode_ssc = (pins.strap == ADCSP_STRAP_SELF);
  assign cs_low   = !pins.cs_n;
  assign load     = conv_busy && (conv_cnt == ADCSP_CONV_LEN - 9'h001);
  assign ssc_shift = (state == ADCSP_SHIFT) && sclk_out && (bit_cnt != BW'(WORD_W - 1));
  // [RULE6] host clock falls shift
  assign sec_shift = !mode_ssc && cs_low && !data_ready_n && sclk_d && !pins.sclk && (bit_cnt != BW'(WORD_W));
  assign ssc_done  = (state == ADCSP_TAIL) && (ph_cnt == ADCSP_TAIL_CYC - 4'h2);
  // [RULE9] last host clock fall
  assign sec_done  = sec_shift && (bit_cnt == BW'(WORD_W - 1));
  // [RULE16] unread word released early
  assign early_release = conv_busy && (conv_cnt == ADCSP_CONV_LEN - 9'h001 - ADCSP_EARLY_CYC)
                         && !data_ready_n && cs_low && (bit_cnt == '0) && (state == ADCSP_IDLE);

  // Only edges of the second synchroniser stage are looked at.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclk_d <= 1'b0;
    end else if (clk_en) begin
      sclk_d <= pins.sclk;
    end
  end

  // [RULE10] conversion timing and filter tap
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      conv_busy <= 1'b0;
      conv_cnt  <= '0;
      filt_hold <= '0;
    end else if (clk_en) begin
      if (conv_busy && conv_cnt == ADCSP_GROUP_DELAY) begin
        filt_hold <= filt_data;
      end
      if (!conv_busy && conv_start) begin
        conv_busy <= 1'b1;
        conv_cnt  <= '0;
      end else if (load) begin
        conv_busy <= 1'b0;
      end else if (conv_busy) begin
        conv_cnt <= conv_cnt + 9'h001;
      end
    end
  end

  // [RULE12] MSB-first shift register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sreg    <= '0;
      bit_cnt <= '0;
    end else if (clk_en) begin
      if (load) begin
        sreg    <= filt_hold;
        bit_cnt <= '0;
      end else if (ssc_shift || sec_shift) begin
        sreg    <= {sreg[WORD_W-2:0], 1'b0};
        bit_cnt <= bit_cnt + BW'(1);
      end
    end
  end
  assign sdo = sreg[WORD_W-1];

  // [RULE15] ready strobe, a new load wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_ready_n <= 1'b1;
    end else if (clk_en) begin
      // [RULE14] load drops ready
      if (load) begin
        data_ready_n <= 1'b0;
      end else if (ssc_done || sec_done || early_release) begin
        data_ready_n <= 1'b1;
      end
    end
  end

  // [RULE2] output enables follow chip select
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sdo_oe  <= 1'b0;
      sclk_oe <= 1'b0;
    end else if (clk_en) begin
      // [RULE7] data driven while selected
      sdo_oe  <= cs_low;
      sclk_oe <= cs_low && mode_ssc;
    end
  end

  // Self-clocked sequencer; a chip select rise aborts the read cleanly.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state    <= ADCSP_IDLE;
      ph_cnt   <= '0;
      sclk_out <= 1'b0;
    end else if (clk_en) begin
      if (!mode_ssc || !cs_low || load) begin
        state    <= ADCSP_IDLE;
        sclk_out <= 1'b0;
      end else begin
        unique case (state)
          // [RULE4] start once selected after ready fell
          ADCSP_IDLE: begin
            if (!data_ready_n && bit_cnt == '0) begin
              state  <= ADCSP_LEAD;
              ph_cnt <= '0;
            end
          end
          // [RULE3] lead-in before first rise
          ADCSP_LEAD: begin
            if (ph_cnt == ADCSP_LEAD_CYC - 4'h1) begin
              sclk_out <= 1'b1;
              state    <= ADCSP_SHIFT;
            end else begin
              ph_cnt <= ph_cnt + 4'h1;
            end
          end
          // [RULE11] toggle every master cycle
          ADCSP_SHIFT: begin
            sclk_out <= !sclk_out;
            if (sclk_out && bit_cnt == BW'(WORD_W - 1)) begin
              state  <= ADCSP_TAIL;
              ph_cnt <= '0;
            end
          end
          // [RULE5] tail before ready rises
          ADCSP_TAIL: begin
            if (ssc_done) begin
              state <= ADCSP_IDLE;
            end else begin
              ph_cnt <= ph_cnt + 4'h1;
            end
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n || !clk_en);

  property p_float_deselect;
    mode_ssc && !cs_low |=> !sclk_oe && !sdo_oe;
  endproperty
  a_float_deselect: assert property (p_float_deselect) else $error("outputs driven while deselected"); // [RULE2]

  property p_first_rise;
    $rose(state == ADCSP_LEAD) ##1 (state == ADCSP_LEAD)[*7] |=> sclk_out;
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("first serial clock rise mistimed"); // [RULE3]

  property p_tail_ready;
    $rose(state == ADCSP_TAIL) ##1 (state == ADCSP_TAIL)[*6] |=> data_ready_n;
  endproperty
  a_tail_ready: assert property (p_tail_ready) else $error("ready not high after tail"); // [RULE5]

  property p_sec_enable;
    !mode_ssc |=> sdo_oe == $past(cs_low);
  endproperty
  a_sec_enable: assert property (p_sec_enable) else $error("data enable not following select"); // [RULE7]

  property p_sec_done;
    sec_done && !load |=> data_ready_n && bit_cnt == BW'(WORD_W);
  endproperty
  a_sec_done: assert property (p_sec_done) else $error("ready not raised after last bit"); // [RULE9]

  property p_group_tap;
    conv_busy && conv_cnt == ADCSP_GROUP_DELAY |=> filt_hold == $past(filt_data);
  endproperty
  a_group_tap: assert property (p_group_tap) else $error("filter result not taken at group delay"); // [RULE10]

  property p_divide;
    (state == ADCSP_SHIFT) ##1 (state == ADCSP_SHIFT) |-> sclk_out != $past(sclk_out);
  endproperty
  a_divide: assert property (p_divide) else $error("serial clock not at half rate"); // [RULE11]

  property p_load;
    load |=> !data_ready_n && sreg == $past(filt_hold) && bit_cnt == '0;
  endproperty
  a_load: assert property (p_load) else $error("word not loaded with ready low"); // [RULE14]

  property p_early;
    early_release |=> data_ready_n ##2 !data_ready_n;
  endproperty
  a_early: assert property (p_early) else $error("unread word release mistimed"); // [RULE16]
endmodule // adcsp_port

/* adcsp_sync.sv */
`timescale 1ns/1ps
package adcsp_pkg;
  // All counts are in master clock cycles; clk is the master clock.
  localparam int         ADCSP_WORD_W      = 24;
  localparam int         ADCSP_CONV_CNT_W  = 9;
  localparam int         ADCSP_PH_CNT_W    = 4;
  localparam logic [8:0] ADCSP_HIGH_CYC    = 9'h162;
  localparam logic [8:0] ADCSP_LOW_CYC     = 9'h040;
  localparam logic [8:0] ADCSP_CONV_LEN    = ADCSP_HIGH_CYC + ADCSP_LOW_CYC;
  localparam logic [8:0] ADCSP_GROUP_DELAY = 9'h0a0;
  localparam logic [8:0] ADCSP_EARLY_CYC   = 9'h002;
  localparam logic [3:0] ADCSP_LEAD_CYC    = 4'h8;
  localparam logic [3:0] ADCSP_TAIL_CYC    = 4'h8;
  localparam logic       ADCSP_STRAP_SELF  = 1'h1;

  typedef struct packed {
    logic strap;
    logic cs_n;
    logic sclk;
  } adcsp_pins_s;

  typedef enum logic [1:0] {
    ADCSP_IDLE  = 2'b00,
    ADCSP_LEAD  = 2'b01,
    ADCSP_SHIFT = 2'b10,
    ADCSP_TAIL  = 2'b11
  } adcsp_state_e;
endpackage

module adcsp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // adcsp_sync

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  import adcsp_pkg::*;
  logic        clk, reset_n, clk_en, conv_start, serial_mode_strap;
  logic        cs_n, sclk_in, sclk_out, sclk_oe, sdo, sdo_oe, data_ready_n;
  logic [23:0] filt_data, w;
  logic [23:0] exp_q[$];
  int          err_count, n_compared, seed, lead, span, tail, k, rk;

  adcsp_port i_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .conv_start(conv_start),
    .filt_data(filt_data), .serial_mode_strap(serial_mode_strap), .cs_n(cs_n), .sclk_in(sclk_in),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdo(sdo), .sdo_oe(sdo_oe), .data_ready_n(data_ready_n));
  adcsp_host i_host (.clk(clk), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdo(sdo), .sdo_oe(sdo_oe),
    .data_ready_n(data_ready_n), .cs_n(cs_n), .sclk_in(sclk_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, e, s);
    end
  endtask

  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The tap value is only present around the capture point, so a tap more than three cycles early or two cycles late reads junk.
  task automatic convert(input bit early);
    logic [23:0] v;
    v = $random(seed);
    @(negedge clk);
    conv_start = 1'b1;
    exp_q.push_back(v);
    @(negedge clk);
    conv_start = 1'b0;
    rk = -1;
    for (k = 0; k < 600; k++) begin
      if (k == 157) filt_data = v;
      if (k == 163) filt_data = ~v;
      if (data_ready_n && rk < 0) rk = k;
      if (!data_ready_n && rk >= 0) break;
      @(negedge clk);
    end
    check("ready fall", 418, k);
    if (early) check("ready release", 2, k - rk);
  endtask

  task automatic idle_check;
    repeat (5) @(negedge clk);
    check("sclk_oe idle", 0, sclk_oe);
    check("sdo_oe idle", 0, sdo_oe);
  endtask

  initial begin
    seed = 32'h243f;
    err_count = 0;
    n_compared = 0;
    clk_en = 1'b1;
    conv_start = 1'b0;
    filt_data = 24'h0;
    serial_mode_strap = 1'b1;
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) begin
      convert(0);
      i_host.read_self(w, lead, span, tail);
      check("self word", exp_q.pop_front(), w);
      check("first rise", 8, lead);
      check("rise span", 46, span);
      check("ready rise", 8, tail);
      idle_check();
    end
    $display("Test self_clocked done");
    serial_mode_strap = 1'b0;
    repeat (4) @(negedge clk);
    convert(0);
    i_host.read_ext(w, tail);
    check("ext word", exp_q.pop_front(), w);
    check("ext ready", 1, 32'(tail > 0 && tail < 6));
    idle_check();
    $display("Test external_clock done");
    i_host.hold_low();
    convert(0);
    void'(exp_q.pop_front());
    convert(1);
    i_host.read_ext(w, tail);
    check("kept word", exp_q.pop_front(), w);
    idle_check();
    $display("Test unread_release done");
    complete_run();
  end

  initial begin
    #400000;
    err_count++;
    complete_run();
  end
endmodule // testbench
